// ===== event_count_pulse_measure_timer.sv
// 16-bit reloading down-counter with event count and pulse measurement
// Functional notes
// - event mode counts the filtered event pin edge; software picks the edge
// - counter decrements per count; underflow reloads and counting continues
// - event mode divides by reload value plus one
// - writing one to the run bit starts counting
// - writing zero to run bit, or one to forced stop, stops counting
// - every mode raises an interrupt pulse on underflow
// - event mode: event pin is input; output pin is port or toggle
// - reading the counter address returns the live down-counter
// - writing the counter address updates only the reload register
// - event mode: polarity, pin, toggle out, filter, gating, event link
// - measure modes take clock, clock/2, clock/8, low speed, subsystem, event link
// - width mode counts while pin shows the selected level
// - end of selected level stops counter and sets edge-received flag
// - width mode interrupts when a width measurement completes
// - period mode captures counter to read-out buffer at next source edge
// - period mode reloads counter at the following source edge
// - period mode interrupts on each selected edge, plus underflow
// - measure modes: pin is measured input; output pin is port or timer out
// - measure modes: level or period choice, pin choice, filter, event link
// - counter and reload register are 16 bits
// - status flag follows run bit after 2 clocks or 3 source counts
// - event mode polarity bit picks one edge or both edges
`timescale 1ns/10ps
`include "evt_timer_regs.svh"
module event_count_pulse_measure_timer (
    // clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        arst_n,
    // control strobes
    input  wire logic                        runWrite,
    input  wire logic                        runValue,
    input  wire logic                        forcedStop,
    input  wire logic                        reloadWrite,
    input  wire logic [`CNT_WIDTH-1:0]       reloadValue,
    input  wire logic                        edgeFlagClear,
    // configuration
    input  wire evt_timer_pkg::mode_type     mode,
    input  wire evt_timer_pkg::src_type      countSrc,
    input  wire evt_timer_pkg::gate_type     gateSel,
    input  wire logic                        gatePolarity,
    input  wire logic                        levelEdgeSel,
    input  wire logic                        bothEdgeSel,
    input  wire logic [1:0]                  filterSel,
    input  wire logic                        toggleOutEnable,
    input  wire logic                        toggleInitHigh,
    // external sources
    input  wire logic                        eventIoPin,
    input  wire logic                        gatePin,
    input  wire logic                        timerOutGate,
    input  wire logic                        lowSpeedOscClock,
    input  wire logic                        subsysClock,
    input  wire logic                        eventLinkPulse,
    // status and results
    output logic                             countStatusFlag,
    output logic                             edgeReceivedFlag,
    output logic [`CNT_WIDTH-1:0]            counterValue,
    output logic [`CNT_WIDTH-1:0]            readoutBuffer,
    output logic                             irqPulse,
    output logic                             toggleOutPin,
    output logic                             toggleOutEn
);
    import evt_timer_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [1:0]            pinSync;
        logic                  pinPrev;
        logic [1:0]            lowSync;
        logic                  lowPrev;
        logic [1:0]            subSync;
        logic                  subPrev;
        logic [1:0]            gateSync;
        logic [2:0]            div;
        logic                  run;
        logic [1:0]            lag;
        logic [`CNT_WIDTH-1:0] cnt;
        logic [`CNT_WIDTH-1:0] reload;
        logic [`CNT_WIDTH-1:0] buffer;
        logic                  capPend;
        logic                  reloadPend;
        logic                  widthDone;
        logic                  status;
        logic                  edgeFlag;
        logic                  irq;
        logic                  tog;
        logic                  togEn;
    } state_type;

    state_type st_r;
    state_type st_nxt;
    logic      pinFilt;
    logic      srcTick;
    logic      rise;
    logic      fall;
    logic      activeEdge;
    logic      gateOpen;
    logic      fastLag;

    // ****************************************
    // input filter
    // ****************************************
    input_filter filt (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .filtSel (filterSel),
        .pinSync (st_r.pinSync[1]),
        .pinFilt (pinFilt)
    );

    // ****************************************
    // count source and edge detection
    // ****************************************
    always_comb begin
        rise = pinFilt & ~st_r.pinPrev;
        fall = ~pinFilt & st_r.pinPrev;
        // selected edge; both edges only meaningful in event mode
        activeEdge = levelEdgeSel ? fall : rise;
        if (mode == MODE_EVENT && bothEdgeSel) begin
            activeEdge = rise | fall;
        end
        case (gateSel)
            GATE_EXT_LEVEL: gateOpen = (st_r.gateSync[1] == gatePolarity);
            GATE_TIMER_OUT: gateOpen = (timerOutGate == gatePolarity);
            default:        gateOpen = 1'b1;
        endcase
        fastLag = (mode == MODE_EVENT) || (countSrc == SRC_EVENT_LINK);
        if (mode == MODE_EVENT) begin
            srcTick = activeEdge & gateOpen;
        end else begin
            case (countSrc)
                SRC_CLK:        srcTick = 1'b1;
                SRC_CLK_DIV2:   srcTick = (st_r.div[0] == 1'b1);
                SRC_CLK_DIV8:   srcTick = (st_r.div == 3'h7);
                SRC_LOW_SPEED:  srcTick = st_r.lowSync[1] & ~st_r.lowPrev;
                SRC_SUBSYS:     srcTick = st_r.subSync[1] & ~st_r.subPrev;
                SRC_EVENT_LINK: srcTick = eventLinkPulse;
                default:        srcTick = 1'b0;
            endcase
        end
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.pinSync = {st_r.pinSync[0], eventIoPin};
        st_nxt.pinPrev = pinFilt;
        st_nxt.lowSync = {st_r.lowSync[0], lowSpeedOscClock};
        st_nxt.lowPrev = st_r.lowSync[1];
        st_nxt.subSync = {st_r.subSync[0], subsysClock};
        st_nxt.subPrev = st_r.subSync[1];
        st_nxt.gateSync = {st_r.gateSync[0], gatePin};
        st_nxt.div = st_r.div + 3'h1;
        st_nxt.irq = 1'b0;

        // writes only touch the reload register
        if (reloadWrite) begin
            st_nxt.reload = reloadValue;
        end
        if (runWrite) begin
            st_nxt.run = runValue;
            st_nxt.lag = '0;
        end
        if (forcedStop) begin
            st_nxt.run = 1'b0;
            st_nxt.status = 1'b0;
            st_nxt.lag = '0;
        end

        // status follows run after a fixed lag
        if (!forcedStop && !runWrite && st_r.status != st_r.run) begin
            if (fastLag || srcTick) begin
                st_nxt.lag = st_r.lag + 2'h1;
            end
            if ((fastLag && st_r.lag == 2'(`START_LAG_FAST - 1) && 1'b1)
                || (!fastLag && srcTick && st_r.lag == 2'(`START_LAG_SLOW - 1))) begin
                st_nxt.status = st_r.run;
                st_nxt.lag = '0;
            end
        end

        // clear first, so a capture in the same cycle still sets the flag
        if (edgeFlagClear) begin
            st_nxt.edgeFlag = 1'b0;
        end

        if (!st_r.run) begin
            st_nxt.capPend = 1'b0;
            st_nxt.reloadPend = 1'b0;
            st_nxt.widthDone = 1'b0;
        end

        if (st_r.status && !forcedStop) begin
            case (mode)
                MODE_WIDTH: begin
                    // active level = high unless select bit set
                    if ((pinFilt ^ levelEdgeSel) && srcTick) begin
                        st_nxt.widthDone = 1'b1;
                        if (st_r.cnt == '0) begin
                            st_nxt.cnt = st_r.reload;
                            st_nxt.irq = 1'b1;
                        end else begin
                            st_nxt.cnt = st_r.cnt - 16'h0001;
                        end
                    end
                    if (st_r.widthDone && !(pinFilt ^ levelEdgeSel)) begin
                        st_nxt.widthDone = 1'b0;
                        st_nxt.edgeFlag = 1'b1;
                        st_nxt.irq = 1'b1;
                    end
                end
                MODE_PERIOD: begin
                    if (activeEdge) begin
                        st_nxt.capPend = 1'b1;
                        st_nxt.irq = 1'b1;
                    end
                    if (srcTick) begin
                        if (st_r.reloadPend) begin
                            st_nxt.cnt = st_r.reload;
                            st_nxt.reloadPend = 1'b0;
                        end else if (st_r.capPend) begin
                            // buffer held while the flag is up
                            if (!st_r.edgeFlag) begin
                                st_nxt.buffer = st_r.cnt;
                            end
                            st_nxt.edgeFlag = 1'b1;
                            st_nxt.capPend = activeEdge;
                            st_nxt.reloadPend = 1'b1;
                        end else if (st_r.cnt == '0) begin
                            st_nxt.cnt = st_r.reload;
                            st_nxt.irq = 1'b1;
                        end else begin
                            st_nxt.cnt = st_r.cnt - 16'h0001;
                        end
                    end
                end
                default: begin
                    // event, timer and pulse-output counting
                    if (srcTick) begin
                        if (st_r.cnt == '0) begin
                            st_nxt.cnt = st_r.reload;
                            st_nxt.irq = 1'b1;
                            st_nxt.tog = ~st_r.tog;
                        end else begin
                            st_nxt.cnt = st_r.cnt - 16'h0001;
                        end
                    end
                end
            endcase
        end else if (!st_r.run) begin
            st_nxt.tog = toggleInitHigh;
        end

        st_nxt.togEn = toggleOutEnable;
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '{cnt: `CNT_RESET, reload: `RELOAD_RESET, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign countStatusFlag  = st_r.status;
    assign edgeReceivedFlag = st_r.edgeFlag;
    assign counterValue     = st_r.cnt;
    assign readoutBuffer    = st_r.buffer;
    assign irqPulse         = st_r.irq;
    assign toggleOutPin     = st_r.tog;
    assign toggleOutEn      = st_r.togEn;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    write_no_count_a: assert property (reloadWrite && !st_r.status |=> counterValue == $past(counterValue))
        else $error("reload write disturbed counter");
    reload_width_a: assert property (reloadWrite |=> st_r.reload == $past(reloadValue))
        else $error("reload register not updated");
    underflow_reload_a: assert property (st_r.status && !forcedStop && mode == MODE_EVENT && srcTick
        && counterValue == 16'h0000 |=> counterValue == $past(st_r.reload) && irqPulse)
        else $error("underflow did not reload or interrupt");
    decrement_a: assert property (st_r.status && !forcedStop && mode == MODE_EVENT && srcTick
        && counterValue != 16'h0000 |=> counterValue == $past(counterValue) - 16'h0001)
        else $error("event count did not decrement");
    stop_a: assert property (forcedStop |=> !countStatusFlag && !st_r.run)
        else $error("forced stop ignored");
    start_lag_a: assert property (runWrite && runValue && !forcedStop && mode == MODE_EVENT && !countStatusFlag
        ##1 !runWrite && !forcedStop [*2] |=> countStatusFlag)
        else $error("status did not follow run in two clocks");
    start_not_early_a: assert property (runWrite && runValue && !countStatusFlag |=> !countStatusFlag)
        else $error("status rose without lag");
    flag_sticky_a: assert property (edgeReceivedFlag && !edgeFlagClear |=> edgeReceivedFlag)
        else $error("edge flag dropped without clear");
    buffer_hold_a: assert property (edgeReceivedFlag |=> $stable(readoutBuffer))
        else $error("read-out buffer moved while flag set");
    width_irq_a: assert property ($rose(edgeReceivedFlag) && mode == MODE_WIDTH |-> irqPulse)
        else $error("width end without interrupt");
    period_irq_a: assert property (st_r.status && !forcedStop && mode == MODE_PERIOD && activeEdge |=> irqPulse)
        else $error("period edge without interrupt");

    event_underflow_c: cover property (mode == MODE_EVENT && irqPulse);
    width_done_c: cover property (mode == MODE_WIDTH && $rose(edgeReceivedFlag));
    period_capture_c: cover property (mode == MODE_PERIOD && $rose(edgeReceivedFlag));
    gated_count_c: cover property (mode == MODE_EVENT && gateSel != GATE_ALWAYS && srcTick);
endmodule : event_count_pulse_measure_timer

// ===== evt_timer_regs.svh
// constants for the event count and pulse measure timer
`ifndef EVT_TIMER_REGS_SVH
`define EVT_TIMER_REGS_SVH
`define CNT_WIDTH        16
`define CNT_RESET        16'hFFFF
`define RELOAD_RESET     16'hFFFF
`define START_LAG_FAST   2
`define START_LAG_SLOW   3
`define FILTER_SAMPLES   3
`define FILT_DIV_2       4'h2
`define FILT_DIV_8       4'h8
`define FILT_DIV_32      6'h20
`endif

// ===== evt_timer_pkg.sv
// types for the event count and pulse measure timer
package evt_timer_pkg;
    typedef enum logic [2:0] {
        MODE_TIMER, MODE_PULSE_OUT, MODE_EVENT, MODE_WIDTH, MODE_PERIOD, MODE_RSV5, MODE_RSV6, MODE_RSV7
    } mode_type;
    typedef enum logic [2:0] {
        SRC_CLK, SRC_CLK_DIV8, SRC_CLK_DIV2, SRC_LOW_SPEED, SRC_EVENT_LINK, SRC_RSV5, SRC_SUBSYS, SRC_RSV7
    } src_type;
    typedef enum logic [1:0] {
        GATE_ALWAYS, GATE_EXT_LEVEL, GATE_TIMER_OUT, GATE_RSV
    } gate_type;
endpackage : evt_timer_pkg

// ===== input_filter.sv
// digital noise filter for the event input pin
`timescale 1ns/10ps
`include "evt_timer_regs.svh"
module input_filter (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       arst_n,
    // configuration
    input  wire logic [1:0] filtSel,
    // signal
    input  wire logic       pinSync,
    output logic            pinFilt
);
    typedef struct packed {
        logic [5:0] div;
        logic [2:0] hist;
        logic       out;
    } state_type;

    state_type st_r;
    state_type st_nxt;
    logic      tick;

    always_comb begin
        case (filtSel)
            2'h1:    tick = 1'b1;
            2'h2:    tick = (st_r.div[2:0] == 3'h0);
            2'h3:    tick = (st_r.div == 6'h00);
            default: tick = 1'b1;
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.div = st_r.div + 6'h01;
        if (filtSel == 2'h0) begin
            st_nxt.out = pinSync;
            st_nxt.hist = {3{pinSync}};
        end else if (tick) begin
            // level must hold three samples in a row to pass
            st_nxt.hist = {st_r.hist[1:0], pinSync};
            if (st_nxt.hist == 3'h7) begin
                st_nxt.out = 1'b1;
            end else if (st_nxt.hist == 3'h0) begin
                st_nxt.out = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pinFilt = st_r.out;
endmodule : input_filter

// ===== pulse_source.sv
// behavioural source of the external pulse or event on the event input pin
`timescale 1ns/10ps
module pulse_source (
    // clock
    input  wire logic ref_clk,
    // pin
    output logic      pinOut
);
    // ****************
    // pin stimulus
    // ****************
    // pin idles low; all changes land on the falling edge
    initial pinOut = 1'b0;

    // holds the pin at lvl for cnt cycles
    task automatic hold(input logic lvl, input int cnt);
        @(negedge ref_clk);
        pinOut = lvl;
        repeat (cnt - 1) @(negedge ref_clk);
    endtask : hold

    // four cycles a level, so the synchroniser never misses one
    task automatic edges(input int n);
        repeat (n) begin
            hold(1'b1, 4);
            hold(1'b0, 4);
        end
    endtask : edges
endmodule : pulse_source

// ===== tb_top.sv
// self-checking testbench for the event count and pulse measure timer
`timescale 1ns/10ps
module tb_top;
    import evt_timer_pkg::*;
    logic        ref_clk, arst_n, runWrite, runValue, forcedStop, reloadWrite, edgeFlagClear;
    logic [15:0] reloadValue, counterValue, readoutBuffer, base, bufHeld;
    mode_type    mode;
    src_type     countSrc;
    gate_type    gateSel;
    logic        gatePolarity, levelEdgeSel, bothEdgeSel, toggleOutEnable, toggleInitHigh;
    logic [1:0]  filterSel;
    logic        eventIoPin, countStatusFlag, edgeReceivedFlag, irqPulse, toggleOutPin, toggleOutEn;
    logic [31:0] seed;
    logic [4:0]  slowDiv = 5'h00;
    logic        gatePin, timerOutGate;
    int          errors, n_tests, cyc, lastIrq, note, k, len;
    int          noteQ[$];
    // ref_clk cycles per count for source codes 0 to 6; code 5 unused
    int          perTab[7] = '{1, 8, 2, 16, 32, 0, 8};

    event_count_pulse_measure_timer u_dut (
        .ref_clk(ref_clk), .arst_n(arst_n), .runWrite(runWrite), .runValue(runValue),
        .forcedStop(forcedStop), .reloadWrite(reloadWrite), .reloadValue(reloadValue),
        .edgeFlagClear(edgeFlagClear), .mode(mode), .countSrc(countSrc), .gateSel(gateSel),
        .gatePolarity(gatePolarity), .levelEdgeSel(levelEdgeSel), .bothEdgeSel(bothEdgeSel),
        .filterSel(filterSel), .toggleOutEnable(toggleOutEnable), .toggleInitHigh(toggleInitHigh),
        .eventIoPin(eventIoPin), .gatePin(gatePin), .timerOutGate(timerOutGate), .lowSpeedOscClock(slowDiv[3]),
        .subsysClock(slowDiv[2]), .eventLinkPulse(slowDiv == 5'h00), .countStatusFlag(countStatusFlag),
        .edgeReceivedFlag(edgeReceivedFlag), .counterValue(counterValue),
        .readoutBuffer(readoutBuffer), .irqPulse(irqPulse), .toggleOutPin(toggleOutPin),
        .toggleOutEn(toggleOutEn)
    );
    pulse_source u_src (.ref_clk(ref_clk), .pinOut(eventIoPin));

    // ****************
    // helpers
    // ****************
    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;
    // slow clocks of 16 and 8 cycles, one event link pulse every 32
    always @(negedge ref_clk) slowDiv <= slowDiv + 5'h01;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish

    // 0 status, 1 edge flag, 2 counter, other: pending irq notes
    task automatic waitFor(input int what, input logic [15:0] v, input int bound);
        logic [15:0] s;
        for (int i = 0; i < bound; i++) begin
            case (what)
                0: s = {15'h0, countStatusFlag};
                1: s = {15'h0, edgeReceivedFlag};
                2: s = counterValue;
                default: s = 16'(noteQ.size());
            endcase
            if (s === v) return;
            @(negedge ref_clk);
        end
        check(s, v);
        tally_and_finish();
    endtask : waitFor

    task automatic setRun(input logic v);
        @(negedge ref_clk);
        runWrite = 1'b1;
        runValue = v;
        @(negedge ref_clk);
        runWrite = 1'b0;
        check({15'h0, countStatusFlag}, {15'h0, ~v});
        waitFor(0, {15'h0, v}, 60);
    endtask : setRun

    // 0 forced stop, 1 reload write, other: edge flag clear
    task automatic pulseCtl(input int which);
        @(negedge ref_clk);
        case (which)
            0: forcedStop = 1'b1;
            1: reloadWrite = 1'b1;
            default: edgeFlagClear = 1'b1;
        endcase
        @(negedge ref_clk);
        forcedStop = 1'b0;
        reloadWrite = 1'b0;
        edgeFlagClear = 1'b0;
    endtask : pulseCtl

    // every irq takes the oldest note; a nonzero note is the expected gap in cycles
    always @(posedge ref_clk) begin
        if (arst_n === 1'b1 && irqPulse === 1'b1) begin
            if (noteQ.size() == 0) check(16'h1, 16'h0);
            else begin
                note = noteQ.pop_front();
                if (note != 0) check(16'(cyc - lastIrq), 16'(note));
            end
            lastIrq = cyc;
        end
    end

    // ****************
    // main sequence
    // ****************
    initial begin
        ref_clk = 1'b0; arst_n = 1'b0; runWrite = 1'b0; runValue = 1'b0; forcedStop = 1'b0;
        reloadWrite = 1'b0; reloadValue = 16'h0014; edgeFlagClear = 1'b0; mode = MODE_EVENT;
        countSrc = SRC_CLK; gateSel = GATE_ALWAYS; gatePolarity = 1'b0; levelEdgeSel = 1'b0;
        bothEdgeSel = 1'b0; toggleOutEnable = 1'b0; toggleInitHigh = 1'b0; seed = 32'hDF1D;
        gatePin = 1'b0; timerOutGate = 1'b0;
        // filter off, so no settling wait is owed before starting
        filterSel = 2'h0;
        errors = 0; n_tests = 0; cyc = 0; lastIrq = 0;
        repeat (20) @(posedge ref_clk);
        @(negedge ref_clk);
        arst_n = 1'b1;
        check(counterValue, 16'hFFFF);
        check({readoutBuffer[14:0], edgeReceivedFlag, countStatusFlag, irqPulse}, 16'h0);
        pulseCtl(1);
        check(counterValue, 16'hFFFF);
        $display("test reset and reload write done");

        k = 3 + int'(rnd() % 8);
        setRun(1'b1);
        u_src.edges(k);
        repeat (6) @(negedge ref_clk);
        check(counterValue, 16'hFFFF - 16'(k));
        setRun(1'b0);
        u_src.edges(2);
        repeat (6) @(negedge ref_clk);
        check(counterValue, 16'hFFFF - 16'(k));
        bothEdgeSel = 1'b1;
        setRun(1'b1);
        u_src.edges(2);
        repeat (6) @(negedge ref_clk);
        base = 16'hFFFF - 16'(k) - 16'h0004;
        check(counterValue, base);
        pulseCtl(0);
        waitFor(0, 16'h0, 3);
        u_src.edges(1);
        repeat (6) @(negedge ref_clk);
        check(counterValue, base);
        toggleOutEnable = 1'b1;
        toggleInitHigh = 1'b1;
        repeat (3) @(negedge ref_clk);
        check({14'h0, toggleOutEn, toggleOutPin}, 16'h0003);
        toggleOutEnable = 1'b0;
        repeat (3) @(negedge ref_clk);
        check({15'h0, toggleOutEn}, 16'h0);
        $display("test event count done");

        mode = MODE_WIDTH;
        bothEdgeSel = 1'b0;
        len = 8 + int'(rnd() % 16);
        noteQ.push_back(0);
        setRun(1'b1);
        u_src.hold(1'b1, len);
        u_src.hold(1'b0, 1);
        waitFor(1, 16'h1, 10);
        waitFor(3, 16'h0, 8);
        check(counterValue, base - 16'(len));
        repeat (5) @(negedge ref_clk);
        check({counterValue[14:0], edgeReceivedFlag}, {base[14:0] - 15'(len), 1'b1});
        pulseCtl(2);
        check({15'h0, edgeReceivedFlag}, 16'h0);
        setRun(1'b0);
        $display("test width measure done");

        mode = MODE_PERIOD;
        setRun(1'b1);
        noteQ.push_back(0);
        u_src.hold(1'b1, 1);
        waitFor(2, 16'h0014, 12);
        check({15'h0, edgeReceivedFlag}, 16'h1);
        bufHeld = readoutBuffer;
        noteQ.push_back(0);
        u_src.hold(1'b0, 3);
        u_src.hold(1'b1, 1);
        waitFor(2, 16'h0014, 12);
        noteQ.push_back(0);
        noteQ.push_back(21);
        noteQ.push_back(21);
        check(readoutBuffer, bufHeld);
        waitFor(3, 16'h0, 80);
        pulseCtl(0);
        pulseCtl(2);
        check({15'h0, edgeReceivedFlag}, 16'h0);
        repeat (30) @(negedge ref_clk);
        $display("test period measure done");

        mode = MODE_EVENT;
        gateSel = GATE_EXT_LEVEL;
        gatePolarity = 1'b1;
        setRun(1'b1);
        base = counterValue;
        u_src.edges(2);
        gatePin = 1'b1;
        u_src.edges(1);
        gateSel = GATE_TIMER_OUT;
        u_src.edges(1);
        timerOutGate = 1'b1;
        u_src.edges(1);
        repeat (6) @(negedge ref_clk);
        check(counterValue, base - 16'h0002);
        pulseCtl(0);
        $display("test event gating done");

        mode = MODE_WIDTH;
        levelEdgeSel = 1'b1;
        filterSel = 2'h1;
        reloadValue = 16'h0003 + 16'(rnd() % 4);
        pulseCtl(1);
        // low is the counted level now; filter settles before any start
        u_src.hold(1'b0, 6);
        for (int s = 0; s < 7; s++) begin
            if (perTab[s] != 0) begin
                countSrc = src_type'(s);
                noteQ.push_back(0);
                noteQ.push_back(perTab[s] * (int'(reloadValue) + 1));
                setRun(1'b1);
                waitFor(3, 16'h0, 900);
                pulseCtl(0);
            end
        end
        $display("test count sources done");
        tally_and_finish();
    end
endmodule : tb_top
